// ===== rtl/lpddr_host_defines.svh
// Named constants of the low-power DDR host controller.
// Assumes a 10 MHz system clock; included by bare name.
`ifndef LPDDR_HOST_DEFINES_SVH
`define LPDDR_HOST_DEFINES_SVH
// Clock period and documented times
`define CLK_NS          100
`define T_INIT_NS       200000
`define T_REFI_NS       7800
`define INIT_CYC        ((`T_INIT_NS + `CLK_NS - 1) / `CLK_NS)
`define REFI_CYC        (`T_REFI_NS / `CLK_NS)
`define REF_LEAD_CYC    64
// Ticks of idle link clock after a command
`define GAP_TICKS       2'h1
`define SREF_EXIT_TICKS 2'h3
`define XFER_PAD        6'h04
// Link clock phases, four system cycles per period
`define PH_CMD          2'h1
`define PH_CMD_SEEN     2'h2
// Write beat timing, in system cycles after the command edge
`define WR_OE_START     6'h04
`define WR_DATA_START   6'h05
// Command codes {cs_n, ras_n, cas_n, we_n}
`define CMD_NOP         4'h7
`define CMD_ACT         4'h3
`define CMD_READ        4'h5
`define CMD_WRITE       4'h4
`define CMD_PRE         4'h2
`define CMD_REF         4'h1
`define CMD_MRS         4'h0
// Mode register selection and address fields
`define BA_BASE_MODE    2'h0
`define BA_EXT_MODE     2'h2
`define AP_BIT          10
`define AP_MASK         13'h0400
`define MR_BL_LSB       0
`define MR_CL_LSB       4
// Software register offsets
`define REG_CTRL        6'h00
`define REG_ADDR        6'h04
`define REG_MODE        6'h08
`define REG_WDATA       6'h0c
`define REG_RDATA       6'h10
`define REG_STATUS      6'h14
`define REG_EMODE       6'h18
// Register field positions
`define CTRL_AP_BIT     3
`define WD_MASK_LSB     16
// Reset values
`define MODE_RESET      7'h33
`define EMODE_RESET     13'h0000
`endif

// ===== rtl/lpddr_host_pkg.sv
// Types shared by the host controller files.
// Assumes nothing beyond a SystemVerilog compiler.
package lpddr_host_pkg;
  // Software operation codes, in order 0..6
  typedef enum logic [2:0] {
    OP_NONE, OP_READ, OP_WRITE, OP_PDOWN, OP_SREF, OP_WAKE, OP_MODE
  } host_op_e;
  // Command sequencer states
  typedef enum logic [3:0] {
    ST_INIT_WAIT, ST_PRE_ALL, ST_REF, ST_REF2, ST_MRS, ST_EMRS, ST_IDLE,
    ST_PRE_ONE, ST_ACT, ST_RW, ST_XFER, ST_PDOWN, ST_SREF
  } host_state_e;
endpackage

// ===== rtl/rd_cap_if.sv
// Signals between the controller and its read capture lanes.
// Assumes both ends run on the system clock.
`timescale 1ns/1ns
interface rd_cap_if;
  logic [1:0]  strobe;
  logic [15:0] data;
  logic        arm;
  logic [15:0] word;
  logic        valid;
  modport capt (input strobe, input data, input arm, output word, output valid);
  modport host (output strobe, output data, output arm, input word, input valid);
endinterface

// ===== rtl/sync2.sv
// Two-flop synchroniser for pin inputs.
// Assumes the inputs are asynchronous to i_clk.
`timescale 1ns/1ns
module sync2 #(
  parameter int W = 18
) (
  // Clock and reset
  input  wire logic         i_clk,
  input  wire logic         i_resetn,
  // Raw and synchronised levels
  input  wire logic [W-1:0] i_d,
  output logic [W-1:0]      o_q
);
  logic [W-1:0] meta;
  // First stage feeds only the second
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      meta <= '0;
      o_q  <= '0;
    end else begin
      meta <= i_d;
      o_q  <= meta;
    end
  end
endmodule // sync2

// ===== rtl/ddr_rd_capture.sv
// Read capture: takes one byte per lane on each strobe edge.
// Assumes strobe and data arrive through the same synchroniser.
`timescale 1ns/1ns
module ddr_rd_capture (
  // Clock and reset
  input  wire logic i_clk,
  input  wire logic i_resetn,
  // Synchronised lanes and captured words
  rd_cap_if.capt    cap
);
  logic [1:0] prev;
  logic [1:0] got;
  logic       valid;
  logic [7:0] lane_byte [2];
  // Edge finding and word completion
  wire [1:0] stb_edge = {2{cap.arm}} & (cap.strobe ^ prev);
  wire [1:0] next_got = got | stb_edge;
  wire       all_got  = &next_got;
  assign cap.valid = valid;
  assign cap.word  = {lane_byte[1], lane_byte[0]};
  // Lane flags and word strobe
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      prev  <= 2'h0;
      got   <= 2'h0;
      valid <= 1'b0;
    end else begin
      prev  <= cap.strobe;
      got   <= (!cap.arm || all_got) ? 2'h0 : next_got;
      valid <= cap.arm && all_got;
    end
  end
  // Each strobe times its own byte lane
  for (genvar g = 0; g < 2; g++) begin : g_lane
    always_ff @(posedge i_clk) begin
      if (stb_edge[g]) begin
        lane_byte[g] <= cap.data[8*g +: 8];
      end
    end
  end
endmodule // ddr_rd_capture

// ===== rtl/lpddr_host_ctrl.sv
// Host controller for a quad-bank low-power DDR memory, x16 data.
// Assumes a 10 MHz clock; memory clock is i_clk divided by four.
//
// Chosen here: strobed register access and the register addresses.
`include "lpddr_host_defines.svh"
`timescale 1ns/1ns
module lpddr_host_ctrl #(
  parameter int INIT_CYC = `INIT_CYC,
  parameter int REFI_CYC = `REFI_CYC
) (
  // Clock and reset
  input  wire logic        i_clk,
  input  wire logic        i_resetn,
  // Register port
  input  wire logic [5:0]  i_addr,
  input  wire logic [31:0] i_wdata,
  input  wire logic        i_wr,
  input  wire logic        i_rd,
  output logic [31:0]      o_rdata,
  // Memory clock and command pins
  output logic             o_ck_p,
  output logic             o_ck_n,
  output logic             o_cke,
  output logic             o_cs_n,
  output logic             o_ras_n,
  output logic             o_cas_n,
  output logic             o_we_n,
  output logic [1:0]       o_bank_select,
  output logic [12:0]      o_addr,
  // Write masks
  output logic             o_lower_byte_mask,
  output logic             o_upper_byte_mask,
  // Data bus
  input  wire logic [15:0] i_data_bus,
  output logic [15:0]      o_data_bus,
  output logic             o_data_bus_oe,
  // Byte strobes
  input  wire logic        i_lower_byte_strobe,
  output logic             o_lower_byte_strobe,
  output logic             o_lower_byte_strobe_oe,
  input  wire logic        i_upper_byte_strobe,
  output logic             o_upper_byte_strobe,
  output logic             o_upper_byte_strobe_oe
);
  localparam logic [11:0] INIT_LAST  = 12'(INIT_CYC);
  localparam logic [7:0]  REF_DUE_AT = 8'(REFI_CYC - `REF_LEAD_CYC);
  localparam logic [7:0]  REF_LIMIT  = 8'(2 * REFI_CYC);

  lpddr_host_pkg::host_state_e state, next_state;
  lpddr_host_pkg::host_op_e    req_op;
  logic [1:0]  ph, gap, next_gap, ba, next_ba, req_bank;
  logic [3:0]  cmd, next_cmd, bank_open, wptr, rptr;
  logic [12:0] a, next_a, req_row, emode;
  logic [12:0] open_row [4];
  logic [8:0]  req_col;
  logic [6:0]  mode;
  logic [23:0] addr_reg;
  logic [11:0] init_cnt;
  logic [7:0]  ref_age;
  logic [5:0]  xfer_cnt, wcyc;
  logic [4:0]  rcnt;
  logic [17:0] wbuf [16];
  logic [15:0] rbuf [16];
  logic [17:0] rd_sync;
  logic [15:0] dq;
  logic [1:0]  dm;
  logic        cke, next_cke, init_done, next_init_done, req_pend, req_ap, ck;
  logic        req_done, ref_issue, pre_all, pre_one, act_issue, rw_issue;
  logic        wr_on, dqs, wr_oe;

  // Link clock phase and command tick
  wire [1:0] next_ph = 2'(ph + 2'h1);
  wire       tick    = (ph == `PH_CMD);
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      ph <= 2'h0;
      ck <= 1'b0;
    end else begin
      ph <= next_ph;
      ck <= ~next_ph[1];
    end
  end

  // Pin inputs pass two flops before any logic
  sync2 #(.W(18)) u_sync (
    .i_clk    (i_clk),
    .i_resetn (i_resetn),
    .i_d      ({i_upper_byte_strobe, i_lower_byte_strobe, i_data_bus}),
    .o_q      (rd_sync)
  );
  rd_cap_if cap ();
  assign cap.strobe = rd_sync[17:16];
  assign cap.data   = rd_sync[15:0];
  assign cap.arm    = (state == lpddr_host_pkg::ST_XFER) && (req_op == lpddr_host_pkg::OP_READ);
  ddr_rd_capture u_cap (
    .i_clk    (i_clk),
    .i_resetn (i_resetn),
    .cap      (cap.capt)
  );

  // Register decode and derived burst figures
  wire        wr_ctrl  = i_wr && (i_addr == `REG_CTRL);
  wire        wr_wdata = i_wr && (i_addr == `REG_WDATA);
  wire        rd_rdata = i_rd && (i_addr == `REG_RDATA);
  wire        take_req = wr_ctrl && (!req_pend || req_done);
  wire [4:0]  nbeats   = 5'h01 << mode[`MR_BL_LSB +: 3];
  wire [5:0]  half_bl  = 6'(nbeats >> 1);
  wire [5:0]  cl_ticks = 6'(mode[`MR_CL_LSB +: 3]);
  wire        row_hit  = bank_open[req_bank] && (open_row[req_bank] == req_row);
  wire        any_open = |bank_open;
  wire        ref_due  = init_done && (ref_age >= REF_DUE_AT);
  wire        is_write = (req_op == lpddr_host_pkg::OP_WRITE);
  wire [31:0] status   = {19'h0, rcnt, bank_open, state == lpddr_host_pkg::ST_SREF,
                          state == lpddr_host_pkg::ST_PDOWN, init_done,
                          state != lpddr_host_pkg::ST_IDLE};
  wire [31:0] rd_mux   = (i_addr == `REG_ADDR)   ? {8'h0, addr_reg} :
                         (i_addr == `REG_MODE)   ? {25'h0, mode} :
                         (i_addr == `REG_EMODE)  ? {19'h0, emode} :
                         (i_addr == `REG_RDATA)  ? {16'h0, rbuf[rptr]} :
                         (i_addr == `REG_STATUS) ? status : 32'h0;

  // Software registers and request latch; a new request beats the clear
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      addr_reg <= 24'h0;
      mode     <= `MODE_RESET;
      emode    <= `EMODE_RESET;
      req_pend <= 1'b0;
      req_op   <= lpddr_host_pkg::OP_NONE;
      req_ap   <= 1'b0;
      o_rdata  <= 32'h0;
    end else begin
      o_rdata <= i_rd ? rd_mux : 32'h0;
      if (i_wr && i_addr == `REG_ADDR) addr_reg <= i_wdata[23:0];
      if (i_wr && i_addr == `REG_MODE) mode <= i_wdata[6:0];
      if (i_wr && i_addr == `REG_EMODE) emode <= i_wdata[12:0];
      if (take_req) begin
        req_pend <= 1'b1;
        req_op   <= lpddr_host_pkg::host_op_e'(i_wdata[2:0]);
        req_ap   <= i_wdata[`CTRL_AP_BIT];
        {req_bank, req_row, req_col} <= addr_reg;
      end else if (req_done) begin
        req_pend <= 1'b0;
      end
    end
  end

  // Power-up wait and refresh age
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      init_cnt <= 12'h0;
      ref_age  <= 8'h0;
    end else begin
      if (init_cnt != INIT_LAST) init_cnt <= 12'(init_cnt + 12'h1);
      if (ref_issue || !init_done || state == lpddr_host_pkg::ST_SREF) ref_age <= 8'h0;
      else if (ref_age != 8'hff) ref_age <= 8'(ref_age + 8'h1);
    end
  end

  // Command sequencer, acting once per link clock
  always_comb begin
    next_state = state;
    next_cmd = cmd;
    next_ba = ba;
    next_a = a;
    next_cke = cke;
    next_gap = gap;
    next_init_done = init_done;
    {req_done, ref_issue, pre_all, pre_one, act_issue, rw_issue} = 6'h0;
    if (tick) begin
      next_cmd = `CMD_NOP;
      if (gap != 2'h0) begin
        next_gap = 2'(gap - 2'h1);
      end else begin
        unique case (state)
          lpddr_host_pkg::ST_INIT_WAIT: begin
            if (init_cnt == INIT_LAST) next_state = lpddr_host_pkg::ST_PRE_ALL;
          end
          lpddr_host_pkg::ST_PRE_ALL: begin
            {next_cmd, next_a, next_gap, pre_all} = {`CMD_PRE, `AP_MASK, `GAP_TICKS, 1'b1};
            next_state = lpddr_host_pkg::ST_REF;
          end
          lpddr_host_pkg::ST_REF, lpddr_host_pkg::ST_REF2: begin
            {next_cmd, next_gap, ref_issue} = {`CMD_REF, `GAP_TICKS, 1'b1};
            next_state = (state == lpddr_host_pkg::ST_REF2) ? lpddr_host_pkg::ST_MRS :
                         init_done ? lpddr_host_pkg::ST_IDLE : lpddr_host_pkg::ST_REF2;
          end
          lpddr_host_pkg::ST_MRS: begin
            {next_cmd, next_ba, next_gap} = {`CMD_MRS, `BA_BASE_MODE, `GAP_TICKS};
            next_a = {6'h0, mode};
            next_state = lpddr_host_pkg::ST_EMRS;
          end
          lpddr_host_pkg::ST_EMRS: begin
            {next_cmd, next_ba, next_a, next_gap} = {`CMD_MRS, `BA_EXT_MODE, emode, `GAP_TICKS};
            next_init_done = 1'b1;
            req_done = req_pend && (req_op == lpddr_host_pkg::OP_MODE);
            next_state = lpddr_host_pkg::ST_IDLE;
          end
          lpddr_host_pkg::ST_IDLE: begin
            if (ref_due) begin
              next_state = any_open ? lpddr_host_pkg::ST_PRE_ALL : lpddr_host_pkg::ST_REF;
            end else if (req_pend) begin
              unique case (req_op)
                lpddr_host_pkg::OP_READ, lpddr_host_pkg::OP_WRITE:
                  next_state = row_hit ? lpddr_host_pkg::ST_RW :
                               bank_open[req_bank] ? lpddr_host_pkg::ST_PRE_ONE :
                               lpddr_host_pkg::ST_ACT;
                lpddr_host_pkg::OP_PDOWN: begin
                  {next_cke, req_done} = 2'b01;
                  next_state = lpddr_host_pkg::ST_PDOWN;
                end
                lpddr_host_pkg::OP_SREF: begin
                  if (any_open) next_state = lpddr_host_pkg::ST_PRE_ALL;
                  else begin
                    {next_cmd, next_cke, ref_issue, req_done} = {`CMD_REF, 3'b011};
                    next_state = lpddr_host_pkg::ST_SREF;
                  end
                end
                lpddr_host_pkg::OP_MODE:
                  next_state = any_open ? lpddr_host_pkg::ST_PRE_ALL : lpddr_host_pkg::ST_MRS;
                default: req_done = 1'b1;
              endcase
            end
          end
          lpddr_host_pkg::ST_PRE_ONE: begin
            {next_cmd, next_ba, next_a, next_gap} = {`CMD_PRE, req_bank, 13'h0, `GAP_TICKS};
            pre_one = 1'b1;
            next_state = lpddr_host_pkg::ST_ACT;
          end
          lpddr_host_pkg::ST_ACT: begin
            {next_cmd, next_ba, next_gap, act_issue} = {`CMD_ACT, req_bank, `GAP_TICKS, 1'b1};
            next_a = req_row;
            next_state = lpddr_host_pkg::ST_RW;
          end
          lpddr_host_pkg::ST_RW: begin
            next_cmd = is_write ? `CMD_WRITE : `CMD_READ;
            next_ba = req_bank;
            next_a = {2'h0, req_ap, 1'b0, req_col};
            rw_issue = 1'b1;
            next_state = lpddr_host_pkg::ST_XFER;
          end
          lpddr_host_pkg::ST_XFER: begin
            if (xfer_cnt == 6'h0) begin
              req_done = 1'b1;
              next_state = lpddr_host_pkg::ST_IDLE;
            end
          end
          lpddr_host_pkg::ST_PDOWN, lpddr_host_pkg::ST_SREF: begin
            if (req_pend || (ref_due && state == lpddr_host_pkg::ST_PDOWN)) begin
              next_cke = 1'b1;
              if (state == lpddr_host_pkg::ST_SREF) next_gap = `SREF_EXIT_TICKS;
              next_state = lpddr_host_pkg::ST_IDLE;
            end
          end
        endcase
      end
    end
  end

  // Sequencer and command pin registers
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      state     <= lpddr_host_pkg::ST_INIT_WAIT;
      {cmd, ba, a, cke, gap, init_done} <= {`CMD_NOP, 2'h0, 13'h0, 1'b1, 2'h0, 1'b0};
    end else begin
      state     <= next_state;
      {cmd, ba, a, cke, gap, init_done} <= {next_cmd, next_ba, next_a, next_cke, next_gap,
                                            next_init_done};
    end
  end

  // Open-row bookkeeping per bank
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      bank_open <= 4'h0;
    end else if (pre_all) begin
      bank_open <= 4'h0;
    end else if (pre_one || (rw_issue && req_ap)) begin
      bank_open[req_bank] <= 1'b0;
    end else if (act_issue) begin
      bank_open[req_bank] <= 1'b1;
      open_row[req_bank]  <= req_row;
    end
  end

  // Transfer budget in link clocks
  always_ff @(posedge i_clk) begin
    if (!i_resetn) xfer_cnt <= 6'h0;
    else if (rw_issue) xfer_cnt <= 6'(half_bl + `XFER_PAD + (is_write ? 6'h0 : cl_ticks));
    else if (tick && state == lpddr_host_pkg::ST_XFER && xfer_cnt != 6'h0)
      xfer_cnt <= 6'(xfer_cnt - 6'h1);
  end

  // Write beat timing: two words per link clock, strobe mid-word
  wire [5:0] wr_end  = 6'(`WR_DATA_START + {nbeats, 1'b0});
  wire [5:0] m       = 6'(wcyc - `WR_DATA_START);
  wire       in_data = wr_on && (wcyc >= `WR_DATA_START) && (m < {nbeats, 1'b0});
  wire       in_oe   = wr_on && (wcyc >= `WR_OE_START) && (wcyc <= wr_end);
  wire [17:0] beat   = wbuf[m[4:1]];
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      {wr_on, wcyc, dq, dm, dqs, wr_oe} <= {1'b0, 6'h0, 16'h0, 2'h0, 1'b0, 1'b0};
    end else begin
      if (rw_issue && is_write) {wr_on, wcyc} <= {1'b1, 6'h0};
      else if (wr_on) {wr_on, wcyc} <= {wcyc != wr_end, 6'(wcyc + 6'h1)};
      dq    <= in_data ? beat[15:0] : 16'h0;
      dm    <= in_data ? beat[`WD_MASK_LSB +: 2] : 2'h0;
      dqs   <= in_data && (m[1] ^ m[0]);
      wr_oe <= in_oe;
    end
  end

  // Write buffer filled by software, read buffer by captured words
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      {wptr, rptr, rcnt} <= {4'h0, 4'h0, 5'h0};
    end else begin
      if (wr_wdata) wptr <= 4'(wptr + 4'h1);
      else if (req_done && state == lpddr_host_pkg::ST_XFER && is_write) wptr <= 4'h0;
      if (rw_issue && !is_write) {rptr, rcnt} <= {4'h0, 5'h0};
      else begin
        if (rd_rdata) rptr <= 4'(rptr + 4'h1);
        if (cap.valid && rcnt != 5'h10) rcnt <= 5'(rcnt + 5'h1);
      end
    end
  end
  always_ff @(posedge i_clk) begin
    if (wr_wdata) wbuf[wptr] <= i_wdata[17:0];
    if (cap.valid && rcnt != 5'h10) rbuf[rcnt[3:0]] <= cap.word;
  end

  // Pin outputs from flops
  assign {o_cs_n, o_ras_n, o_cas_n, o_we_n} = cmd;
  assign {o_ck_p, o_ck_n, o_cke}            = {ck, ~ck, cke};
  assign {o_bank_select, o_addr}            = {ba, a};
  assign {o_upper_byte_mask, o_lower_byte_mask} = dm;
  assign {o_data_bus, o_data_bus_oe}        = {dq, wr_oe};
  assign {o_lower_byte_strobe, o_upper_byte_strobe}       = {dqs, dqs};
  assign {o_lower_byte_strobe_oe, o_upper_byte_strobe_oe} = {wr_oe, wr_oe};

  // Checks on the pin behaviour
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_resetn);
  chk_cmd_edge_align: assert property ($changed(cmd) |-> ph == `PH_CMD_SEEN)
    else $error("command pins changed away from the falling clock");
  chk_init_idle_cmds: assert property (!init_done && state == lpddr_host_pkg::ST_INIT_WAIT
    |-> cmd == `CMD_NOP && init_cnt <= INIT_LAST)
    else $error("command issued during power-up wait");
  chk_mode_zero_bits: assert property (cmd == `CMD_MRS && ba == `BA_BASE_MODE
    |-> a[12:7] == 6'h0 && a[6:0] == mode)
    else $error("base mode opcode wrong");
  chk_mode_bank_sel: assert property ($rose(cmd == `CMD_MRS) && ba == `BA_BASE_MODE
    |-> ##8 cmd == `CMD_MRS && ba == `BA_EXT_MODE)
    else $error("mode register write order wrong");
  chk_row_open_use: assert property (tick && next_cmd inside {`CMD_READ, `CMD_WRITE}
    |-> bank_open[next_ba] && open_row[next_ba] == req_row)
    else $error("column command to closed bank");
  chk_refresh_spacing: assert property (state != lpddr_host_pkg::ST_SREF
    |-> ref_age <= REF_LIMIT)
    else $error("refresh interval exceeded");
  chk_autoclose_flag: assert property (rw_issue |=> a[`AP_BIT] == req_ap
    && ba == req_bank && !bank_open[ba] == req_ap)
    else $error("auto close flag or bank mismatch");
  chk_strobe_centre: assert property ($rose(dqs) |-> $stable(dq) && $stable(dm)
    ##2 $fell(dqs) && $stable(dq) && $stable(dm))
    else $error("strobe not centred in data eye");
  chk_two_words_clk: assert property (wr_oe && $past(wr_oe) && ($changed(dq) || $changed(dm))
    |-> ph[0] == 1'b0)
    else $error("data beat not on clock edge");
  chk_lane_enables: assert property (o_lower_byte_strobe_oe == o_upper_byte_strobe_oe
    && o_data_bus_oe == wr_oe && (!dqs || wr_oe))
    else $error("byte lanes disagree");
  cov_write_burst: cover property (rw_issue && is_write ##[1:60] !wr_on);
  cov_read_word: cover property (cap.valid);
  cov_self_refresh: cover property (state == lpddr_host_pkg::ST_SREF);
  cov_refresh_run: cover property (ref_issue && init_done);
endmodule // lpddr_host_ctrl

// ===== tb/lpddr_dev_model.sv
// Behavioural model of the memory device facing the host controller.
// Assumes strobe lines idle low through a pull-down when nobody drives.
`timescale 1ns/1ns
module lpddr_dev_model (
  // Command pins
  input  wire logic        i_ck, i_cke, i_cs_n, i_ras_n, i_cas_n, i_we_n,
  input  wire logic [1:0]  i_ba,
  input  wire logic [12:0] i_a,
  // Write data, masks and strobes
  input  wire logic [15:0] i_dq,
  input  wire logic [1:0]  i_dm, i_dqs,
  // Read data and strobe
  output logic [15:0]      o_dq,
  output logic             o_dqs
);
  logic [15:0] mem [256];
  logic [6:0]  mode = 7'h00;
  logic [7:0]  col = 8'h00;
  logic [4:0]  h = 5'h1f, bl = 5'h0, e, cl2;
  logic [4:0]  wb [2];
  logic [3:0]  cmd;
  initial begin
    for (int i = 0; i < 256; i++) mem[i] = 16'ha5a5;
    o_dq = 16'h0000;
    o_dqs = 1'b0;
  end
  // Column of beat k, sequential or interleaved
  function automatic logic [7:0] loc(input logic [4:0] k);
    logic [7:0] m;
    m = {3'h0, bl - 5'h1};
    loc = mode[3] ? (col ^ {3'h0, k}) : ((col & ~m) | ((col + {3'h0, k}) & m));
  endfunction
  assign cmd = {i_cs_n, i_ras_n, i_cas_n, i_we_n};
  assign cl2 = {1'b0, mode[6:4], 1'b0};
  // Commands taken at clock rise while enabled and selected
  always @(posedge i_ck) if (i_cke && !i_cs_n) begin
    if (cmd == 4'h0 && i_ba == 2'h0) mode <= i_a[6:0];
    if (cmd == 4'h5 || cmd == 4'h4) begin
      col <= {i_ba, i_a[5:0]};
      bl <= 5'h1 << mode[2:0];
    end
    if (cmd == 4'h5) h <= 5'h0;
    if (cmd == 4'h4) wb <= '{5'h0, 5'h0};
  end
  // Read beats edge-aligned on both clock edges, then release
  always @(i_ck) if (h != 5'h1f) begin
    e = h + 5'h1;
    h <= (e >= cl2 + bl) ? 5'h1f : e;
    if (e >= cl2 && e < cl2 + bl) begin
      o_dq <= mem[loc(e - cl2)];
      o_dqs <= ~e[0];
    end else if (e >= cl2 + bl) begin
      o_dq <= ~o_dq;
      o_dqs <= 1'b0;
    end
  end
  // Write capture per byte lane on each edge of its own strobe
  for (genvar g = 0; g < 2; g++) begin : lane
    always @(i_dqs[g]) if (wb[g] < bl) begin
      if (!i_dm[g]) mem[loc(wb[g])][8*g +: 8] <= i_dq[8*g +: 8];
      wb[g] <= wb[g] + 5'h1;
    end
  end
endmodule // lpddr_dev_model

// ===== tb/tb_top.sv
// Self-checking bench: host controller against the device model.
// Assumes design and model files are compiled before this one.
`timescale 1ns/1ns
module tb_top;
  logic        i_clk = 0, i_resetn = 0, i_wr = 0, i_rd = 0, mon = 0;
  logic [5:0]  i_addr = 6'h00;
  logic [31:0] i_wdata = 32'h0, o_rdata, v;
  logic        ck_p, ck_n, cke, cs_n, ras_n, cas_n, we_n, dm_l, dm_u, dq_oe;
  logic        sl, sl_oe, su, su_oe, dqs;
  logic [1:0]  ba;
  logic [12:0] a;
  logic [15:0] dq_h, dq_d;
  int          error_cnt = 0, checks = 0, cyc = 0, gap = 0, mx = 0, k = 0;
  typedef struct {logic [23:0] ad; logic [17:0] w0, w1; logic [15:0] e0, e1;} row_s;
  row_s rows[2] = '{'{24'h400604, 18'h01234, 18'h1abcd, 16'h1234, 16'haba5},
                    '{24'h800605, 18'h25678, 18'h39999, 16'ha578, 16'ha5a5}};
  // Sleep ops: op code in the high nibble, command at entry in the low
  logic [7:0]  slp[2] = '{8'h37, 8'h41};
  always #50 i_clk = ~i_clk;
  lpddr_host_ctrl #(.INIT_CYC(8), .REFI_CYC(100)) lpddr_host_ctrl_inst (
    .i_clk(i_clk), .i_resetn(i_resetn), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
    .i_rd(i_rd), .o_rdata(o_rdata), .o_ck_p(ck_p), .o_ck_n(ck_n), .o_cke(cke),
    .o_cs_n(cs_n), .o_ras_n(ras_n), .o_cas_n(cas_n), .o_we_n(we_n), .o_bank_select(ba),
    .o_addr(a), .o_lower_byte_mask(dm_l), .o_upper_byte_mask(dm_u),
    .i_data_bus(dq_oe ? dq_h : dq_d), .o_data_bus(dq_h), .o_data_bus_oe(dq_oe),
    .i_lower_byte_strobe(sl_oe ? sl : dqs), .o_lower_byte_strobe(sl),
    .o_lower_byte_strobe_oe(sl_oe), .i_upper_byte_strobe(su_oe ? su : dqs),
    .o_upper_byte_strobe(su), .o_upper_byte_strobe_oe(su_oe));
  lpddr_dev_model dev_model_inst (
    .i_ck(ck_p), .i_cke(cke), .i_cs_n(cs_n), .i_ras_n(ras_n), .i_cas_n(cas_n),
    .i_we_n(we_n), .i_ba(ba), .i_a(a), .i_dq(dq_h), .i_dm({dm_u, dm_l}),
    .i_dqs({su & su_oe, sl & sl_oe}), .o_dq(dq_d), .o_dqs(dqs));
  // Timeout and longest gap between refresh commands
  always @(posedge i_clk) begin
    cyc++;
    gap = (!mon || {cs_n, ras_n, cas_n, we_n} == 4'h1) ? 0 : gap + 1;
    if (gap > mx) mx = gap;
    if (cyc == 20000) begin
      error_cnt++;
      report_and_stop();
    end
  end
  task automatic chk(input logic [31:0] g, ex, input string n);
    checks++;
    if (g !== ex) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", n, ex, g);
    end
  endtask
  task automatic wr(input logic [5:0] ad, input logic [31:0] d);
    @(posedge i_clk);
    i_addr <= ad;
    i_wdata <= d;
    i_wr <= 1'b1;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask
  task automatic rd(input logic [5:0] ad);
    @(posedge i_clk);
    i_addr <= ad;
    i_rd <= 1'b1;
    @(posedge i_clk);
    i_rd <= 1'b0;
    @(negedge i_clk);
    v = o_rdata;
  endtask
  // Two idle reads far apart: a refresh can leave a request waiting in idle
  task automatic idle();
    int seen;
    seen = 0;
    while (seen < 2) begin
      repeat (10) @(posedge i_clk);
      rd(6'h14);
      seen = (v[0] === 1'b0) ? seen + 1 : 0;
    end
  endtask
  task automatic report_and_stop();
    $display("checks %0d error_cnt %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  initial begin
    repeat (5) @(posedge i_clk);
    chk({28'h0, cs_n, ras_n, cas_n, we_n}, 32'h7, "reset cmd");
    i_resetn <= 1'b1;
    idle();
    mon = 1;
    rd(6'h14);
    chk({31'h0, v[1]}, 32'h1, "init done");
    rd(6'h08);
    chk(v, 32'h33, "mode reset");
    wr(6'h08, 32'h31);
    wr(6'h00, 32'h6);
    idle();
    chk({25'h0, dev_model_inst.mode}, 32'h31, "mode pins");
    rd(6'h3c);
    chk(v, 32'h0, "unmapped");
    foreach (rows[i]) begin
      wr(6'h04, {8'h0, rows[i].ad});
      wr(6'h0c, {14'h0, rows[i].w0});
      wr(6'h0c, {14'h0, rows[i].w1});
      wr(6'h00, 32'h2);
      idle();
      wr(6'h00, 32'h1);
      idle();
      rd(6'h10);
      chk(v, {16'h0, rows[i].e0}, "beat0");
      rd(6'h10);
      chk(v, {16'h0, rows[i].e1}, "beat1");
    end
    wr(6'h00, 32'h9);
    idle();
    rd(6'h14);
    chk({31'h0, v[6]}, 32'h0, "autoclose bank");
    rd(6'h10);
    chk(v, 32'ha578, "autoclose beat0");
    foreach (slp[i]) begin
      wr(6'h00, {28'h0, slp[i][7:4]});
      for (k = 0; k < 60 && cke; k++) @(posedge i_clk);
      chk({31'h0, cke}, 32'h0, "sleep cke");
      chk({28'h0, cs_n, ras_n, cas_n, we_n}, {28'h0, slp[i][3:0]}, "sleep cmd");
      wr(6'h00, 32'h5);
      idle();
      chk({31'h0, cke}, 32'h1, "wake cke");
    end
    chk({31'h0, mx <= 100}, 32'h1, "refresh gap");
    report_and_stop();
  end
endmodule // tb_top
